//--- rtl/ddc_params.svh
// Constants for the dual DAC control link: frame layout, timing and host register map.
`ifndef DDC_PARAMS_SVH
`define DDC_PARAMS_SVH

`define DDC_FRAME_BITS 16
`define DDC_CODE_W 12
`define DDC_BIT_CHAN 15
`define DDC_BIT_BUF 14
`define DDC_BIT_MODE_HI 13
`define DDC_BIT_MODE_LO 12
`define DDC_CODE_MSB 11
`define DDC_BYTE_BITS 8

`define DDC_CLK_NS 100
`define DDC_REC_5V_NS 2500
`define DDC_REC_3V_NS 5000
`define DDC_REC_5V_CYC ((`DDC_REC_5V_NS + `DDC_CLK_NS - 1) / `DDC_CLK_NS)
`define DDC_REC_3V_CYC ((`DDC_REC_3V_NS + `DDC_CLK_NS - 1) / `DDC_CLK_NS)

`define DDC_SCLK_HALF 4
`define DDC_BYTE_GAP 8
`define DDC_LOAD_LOW 8

`define DDC_REG_FRAME 12'h000
`define DDC_REG_CTRL 12'h004
`define DDC_REG_STATUS 12'h008
`define DDC_REG_LAST 12'h00C
`define DDC_CTRL_BYTE 0
`define DDC_CTRL_LOAD 1
`define DDC_CTRL_RESET 32'h0000_0000

`endif

//--- rtl/ddc_pkg.sv
// Types shared by both ends of the dual DAC control link.
package ddc_pkg;
    typedef enum logic [1:0] {
        DDC_NORMAL,
        DDC_PD_1K,
        DDC_PD_100K,
        DDC_PD_OPEN
    } ddc_mode_e;

    typedef logic [11:0] ddc_code_t;
endpackage

//--- rtl/ddc_link_if.sv
// Three-wire serial link plus load strobe between host and converter control.
`timescale 1ns/1ps
interface ddc_link_if;
    logic sclk;
    logic din;
    logic sync_n;
    logic load_strobe_n;

    modport host (
        output sclk,
        output din,
        output sync_n,
        output load_strobe_n
    );
    modport dev (
        input sclk,
        input din,
        input sync_n,
        input load_strobe_n
    );
endinterface

//--- rtl/ddc_sync2.sv
// Two-flop synchroniser for one pin level.
`timescale 1ns/1ps
module ddc_sync2 #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_async,
    output logic o_sync
);
    logic meta;

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            meta <= RST_VAL;
            o_sync <= RST_VAL;
        end else begin
            meta <= i_async;
            o_sync <= meta;
        end
    end
endmodule

//--- rtl/ddc_device.sv
// Converter-side control: serial frame receiver, double-buffered codes and power-down control.
//
// What this block does
// - Valid frame loads addressed channel's input register.
// - Strobe high: DAC register holds its value.
// - Strobe low: DAC register follows input register.
// - Both channels transfer together on one strobe.
// - Only channels written since last update transfer.
// - Mode comes from frame bits thirteen, twelve.
// - Mode codes: normal, 1k, 100k, open.
// - Each channel keeps its own mode.
// - Power-down swaps amplifier for 1k or 100k pull; open mode leaves output unterminated.
// - Power-down shuts bias, amplifier, string down.
// - Registers survive power-down unchanged.
// - Settled only after recovery delay from power-down.
// - Host holds frame sync low whole word.
// - Host idles clock low, data valid falling.
// - Byte hosts keep sync low across bytes.
// - Words go most significant bit first.
// - DSP host: internal clock, low sync, 16 bits.
// - Frame: channel, buffer, mode, code MSB first.
// - Sixteen falling edges shift; extra clocks ignored.
// - Early sync rise aborts, registers unchanged.
// - Reset clears registers, normal mode, unbuffered.
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "ddc_params.svh"
module ddc_device #(
    parameter int CODE_W = `DDC_CODE_W
) (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    ddc_link_if.dev link,
    input wire logic i_low_supply,
    output ddc_pkg::ddc_code_t o_dac_a,
    output ddc_pkg::ddc_code_t o_dac_b,
    output ddc_pkg::ddc_code_t o_input_a,
    output ddc_pkg::ddc_code_t o_input_b,
    output ddc_pkg::ddc_mode_e o_mode_a,
    output ddc_pkg::ddc_mode_e o_mode_b,
    output logic [1:0] o_ref_buffered,
    output logic [1:0] o_pending,
    output logic [1:0] o_amp_connected,
    output logic [1:0] o_pull_1k,
    output logic [1:0] o_pull_100k,
    output logic [1:0] o_shutdown,
    output logic [1:0] o_settled,
    output logic o_frame_done,
    output logic o_frame_abort
);
    import ddc_pkg::*;

    localparam int LOW_CUT = `DDC_CODE_MSB + 1 - CODE_W;
    localparam logic [5:0] REC_5V = 6'(`DDC_REC_5V_CYC);
    localparam logic [5:0] REC_3V = 6'(`DDC_REC_3V_CYC);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    logic sclk_s;
    logic din_s;
    logic sync_n_s;
    logic load_n_s;

    ddc_sync2 #(.RST_VAL(1'b0)) u_sync_sclk (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_async(link.sclk),
        .o_sync(sclk_s)
    );
    ddc_sync2 #(.RST_VAL(1'b0)) u_sync_din (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_async(link.din),
        .o_sync(din_s)
    );
    ddc_sync2 #(.RST_VAL(1'b1)) u_sync_frame (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_async(link.sync_n),
        .o_sync(sync_n_s)
    );
    ddc_sync2 #(.RST_VAL(1'b1)) u_sync_load (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_async(link.load_strobe_n),
        .o_sync(load_n_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Frame receiver.

    logic sclk_d;
    logic sync_n_d;
    logic [15:0] shift;
    logic [4:0] bit_cnt;
    logic sclk_fall;
    logic commit;
    logic [15:0] word;

    assign sclk_fall = sclk_d & ~sclk_s;
    assign commit = !sync_n_s && sclk_fall && bit_cnt == 5'(`DDC_FRAME_BITS - 1);
    assign word = {shift[14:0], din_s};

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            sclk_d <= 1'b0;
            sync_n_d <= 1'b1;
        end else begin
            sclk_d <= sclk_s;
            sync_n_d <= sync_n_s;
        end
    end

    // Once sixteen edges are in, the counter parks at sixteen until sync rises.
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            shift <= 16'h0000;
            bit_cnt <= 5'h00;
        end else if (sync_n_s) begin
            bit_cnt <= 5'h00;
        end else if (sclk_fall && bit_cnt < 5'(`DDC_FRAME_BITS)) begin
            shift <= word;
            bit_cnt <= bit_cnt + 5'h01;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            o_frame_done <= 1'b0;
            o_frame_abort <= 1'b0;
        end else begin
            o_frame_done <= commit;
            o_frame_abort <= sync_n_s && !sync_n_d && bit_cnt != 5'(`DDC_FRAME_BITS);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-channel registers, transfer and power-down.

    ddc_code_t in_reg [2];
    ddc_code_t dac_reg [2];
    ddc_mode_e mode [2];
    ddc_code_t new_code;

    // Bits below the configured width are dropped so a narrow part reads them as zero.
    always_comb begin
        new_code = '0;
        new_code[`DDC_CODE_MSB:LOW_CUT] = word[`DDC_CODE_MSB:LOW_CUT];
    end

    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
        logic hit;
        logic [5:0] rec_cnt;
        ddc_mode_e next_mode;

        assign hit = commit && (word[`DDC_BIT_CHAN] == 1'(ch));
        assign next_mode = ddc_mode_e'({word[`DDC_BIT_MODE_HI], word[`DDC_BIT_MODE_LO]});

        always_ff @(posedge i_sys_clk) begin
            if (!i_nrst) begin
                in_reg[ch] <= '0;
                mode[ch] <= DDC_NORMAL;
                o_ref_buffered[ch] <= 1'b0;
            end else if (hit) begin
                in_reg[ch] <= new_code;
                mode[ch] <= next_mode;
                o_ref_buffered[ch] <= word[`DDC_BIT_BUF];
            end
        end

        // The pending flag lets a strobe skip channels that did not change, which
        // saves needless glitches; a write in the transfer cycle keeps it set.
        always_ff @(posedge i_sys_clk) begin
            if (!i_nrst) begin
                dac_reg[ch] <= '0;
                o_pending[ch] <= 1'b0;
            end else begin
                if (!load_n_s && o_pending[ch]) begin
                    dac_reg[ch] <= in_reg[ch];
                end
                if (hit) begin
                    o_pending[ch] <= 1'b1;
                end else if (!load_n_s) begin
                    o_pending[ch] <= 1'b0;
                end
            end
        end

        always_ff @(posedge i_sys_clk) begin
            if (!i_nrst) begin
                o_amp_connected[ch] <= 1'b1;
                o_pull_1k[ch] <= 1'b0;
                o_pull_100k[ch] <= 1'b0;
                o_shutdown[ch] <= 1'b0;
            end else begin
                o_amp_connected[ch] <= mode[ch] == DDC_NORMAL;
                o_pull_1k[ch] <= mode[ch] == DDC_PD_1K;
                o_pull_100k[ch] <= mode[ch] == DDC_PD_100K;
                o_shutdown[ch] <= mode[ch] != DDC_NORMAL;
            end
        end

        // Recovery count restarts whenever the channel is powered down.
        always_ff @(posedge i_sys_clk) begin
            if (!i_nrst) begin
                rec_cnt <= 6'h00;
                o_settled[ch] <= 1'b1;
            end else if (mode[ch] != DDC_NORMAL) begin
                rec_cnt <= i_low_supply ? REC_3V : REC_5V;
                o_settled[ch] <= 1'b0;
            end else if (rec_cnt != 6'h00) begin
                rec_cnt <= rec_cnt - 6'h01;
                o_settled[ch] <= rec_cnt == 6'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered views of the channel state.

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            o_dac_a <= '0;
            o_dac_b <= '0;
            o_input_a <= '0;
            o_input_b <= '0;
            o_mode_a <= DDC_NORMAL;
            o_mode_b <= DDC_NORMAL;
        end else begin
            o_dac_a <= dac_reg[0];
            o_dac_b <= dac_reg[1];
            o_input_a <= in_reg[0];
            o_input_b <= in_reg[1];
            o_mode_a <= mode[0];
            o_mode_b <= mode[1];
        end
    end
endmodule

//--- rtl/ddc_host.sv
// Host-side controller: APB registers drive frame transmission and the load strobe.
`timescale 1ns/1ps
`include "ddc_params.svh"
module ddc_host (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    ddc_link_if.host link
);
    import ddc_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_HIGH,
        ST_LOW,
        ST_GAP,
        ST_END,
        ST_LOAD
    } ddc_host_e;

    ddc_host_e state;
    logic [31:0] ctrl;
    logic [15:0] frame;
    logic [15:0] last;
    logic [4:0] bits_left;
    logic [3:0] tick;
    logic start;
    logic load_req;
    logic access;
    logic busy;

    assign access = i_psel && i_penable && !o_pready;
    assign busy = state != ST_IDLE;

    ////////////////////////////////////////////////////////////////////////////
    // APB slave; every access answers one cycle after penable rises.

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h0000_0000;
            ctrl <= `DDC_CTRL_RESET;
            frame <= 16'h0000;
            start <= 1'b0;
        end else begin
            o_pready <= access;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h0000_0000;
            start <= 1'b0;
            if (access) begin
                case (i_paddr)
                    `DDC_REG_FRAME: begin
                        o_prdata <= {16'h0000, frame};
                        if (i_pwrite && !busy) begin
                            frame <= i_pwdata[15:0];
                            start <= 1'b1;
                        end
                    end
                    `DDC_REG_CTRL: begin
                        o_prdata <= ctrl;
                        if (i_pwrite) begin
                            ctrl <= {30'h0000_0000, i_pwdata[1:0]};
                        end
                    end
                    `DDC_REG_STATUS: o_prdata <= {31'h0000_0000, busy};
                    `DDC_REG_LAST: o_prdata <= {16'h0000, last};
                    default: o_pslverr <= 1'b1;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link sequencer: clock idles low, data changes on the rising edge.

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            state <= ST_IDLE;
            link.sclk <= 1'b0;
            link.din <= 1'b0;
            link.sync_n <= 1'b1;
            link.load_strobe_n <= 1'b1;
            bits_left <= 5'h00;
            tick <= 4'h0;
            last <= 16'h0000;
            load_req <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        link.sync_n <= 1'b0;
                        bits_left <= 5'(`DDC_FRAME_BITS);
                        load_req <= ctrl[`DDC_CTRL_LOAD];
                        tick <= 4'(`DDC_SCLK_HALF - 1);
                        state <= ST_LOW;
                    end
                end
                ST_HIGH: begin
                    if (tick == 4'h0) begin
                        link.sclk <= 1'b0;
                        tick <= 4'(`DDC_SCLK_HALF - 1);
                        bits_left <= bits_left - 5'h01;
                        state <= ST_LOW;
                    end else begin
                        tick <= tick - 4'h1;
                    end
                end
                ST_LOW: begin
                    if (tick != 4'h0) begin
                        tick <= tick - 4'h1;
                    end else if (bits_left == 5'h00) begin
                        tick <= 4'(`DDC_SCLK_HALF - 1);
                        state <= ST_END;
                    end else if (ctrl[`DDC_CTRL_BYTE] && bits_left == 5'(`DDC_BYTE_BITS)) begin
                        tick <= 4'(`DDC_BYTE_GAP - 1);
                        state <= ST_GAP;
                    end else begin
                        link.sclk <= 1'b1;
                        link.din <= frame[4'(bits_left - 5'h01)];
                        tick <= 4'(`DDC_SCLK_HALF - 1);
                        state <= ST_HIGH;
                    end
                end
                ST_GAP: begin
                    if (tick == 4'h0) begin
                        link.sclk <= 1'b1;
                        link.din <= frame[4'(bits_left - 5'h01)];
                        tick <= 4'(`DDC_SCLK_HALF - 1);
                        state <= ST_HIGH;
                    end else begin
                        tick <= tick - 4'h1;
                    end
                end
                ST_END: begin
                    if (tick == 4'h0) begin
                        link.sync_n <= 1'b1;
                        last <= frame;
                        tick <= 4'(`DDC_LOAD_LOW - 1);
                        if (load_req) begin
                            link.load_strobe_n <= 1'b0;
                            state <= ST_LOAD;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end else begin
                        tick <= tick - 4'h1;
                    end
                end
                ST_LOAD: begin
                    if (tick == 4'h0) begin
                        link.load_strobe_n <= 1'b1;
                        state <= ST_IDLE;
                    end else begin
                        tick <= tick - 4'h1;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule

//--- verif/ddc_link_monitor.sv
// Checker for the host end of the dual DAC serial link and its load strobe.
`timescale 1ns/1ps
module ddc_link_monitor (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_sclk,
    input wire logic i_din,
    input wire logic i_sync_n,
    input wire logic i_load_strobe_n
);
    logic sclk_q;
    logic [4:0] fall_cnt;

    default clocking mon_cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_nrst);

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_sys_clk) begin
        sclk_q <= i_sclk;
    end

    // Counts falling shift-clock edges of the current frame; idle frames hold it at zero.
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst || i_sync_n) begin
            fall_cnt <= 5'h00;
        end else if (sclk_q && !i_sclk) begin
            fall_cnt <= fall_cnt + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    clk_idle_low_a: assert property (i_sync_n |-> !i_sclk)
        else $error("Shift clock high outside a frame.");
    frame_gate_a: assert property ($rose(i_sclk) |-> !i_sync_n)
        else $error("Shift clock rose while the frame sync was high.");
    clk_high_width_a: assert property ($rose(i_sclk) |-> i_sclk [*4] ##1 !i_sclk)
        else $error("Shift clock high phase is not four cycles.");
    data_hold_a: assert property ($past(i_sclk) |-> $stable(i_din))
        else $error("Serial data moved while the shift clock was high or falling.");
    frame_len_a: assert property ($rose(i_sync_n) |-> fall_cnt == 5'h10)
        else $error("Frame sync rose after a count other than sixteen edges.");
    edge_limit_a: assert property (fall_cnt <= 5'h10)
        else $error("More than sixteen falling edges in one frame.");
    sync_lead_a: assert property ($fell(i_sync_n) |-> !i_sclk ##[1:8] $rose(i_sclk))
        else $error("No shift clock soon after the frame sync fell.");
    load_width_a: assert property ($fell(i_load_strobe_n) |-> (!i_load_strobe_n) [*8] ##1 i_load_strobe_n)
        else $error("Load strobe low phase is not eight cycles.");
    load_outside_a: assert property (!i_load_strobe_n |-> i_sync_n)
        else $error("Load strobe low during a frame.");
endmodule

//--- verif/dual_dac_update_powerdown_ctrl_bench.sv
// Bench: APB host end and converter end joined by the link, plus a bench-driven link for faults.
`timescale 1ns/1ps
`include "ddc_params.svh"
module dual_dac_update_powerdown_ctrl_bench;
    import ddc_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, low_supply = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, done, done2, abort2, err, wire_q;
    ddc_code_t dac_a, dac_b, in_a, in_b, in2_a, in2_b;
    ddc_mode_e mode_a, mode_b;
    logic [1:0] ref_buf, pend, amp, p1k, p100k, sd, settled;
    logic [15:0] wire_word;
    int failures = 0, checks = 0, cycles = 0, aborts = 0, frames2 = 0, m, s;

    ddc_link_if link();
    ddc_link_if link2();

    always #50 i_sys_clk = ~i_sys_clk;

    ddc_host u_ddc_host (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .link(link));
    ddc_device u_ddc_device (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .link(link), .i_low_supply(low_supply),
        .o_dac_a(dac_a), .o_dac_b(dac_b), .o_input_a(in_a), .o_input_b(in_b), .o_mode_a(mode_a),
        .o_mode_b(mode_b), .o_ref_buffered(ref_buf), .o_pending(pend), .o_amp_connected(amp),
        .o_pull_1k(p1k), .o_pull_100k(p100k), .o_shutdown(sd), .o_settled(settled),
        .o_frame_done(done), .o_frame_abort());
    // Narrow code width so that discarded low bits show up at the input registers.
    ddc_device #(.CODE_W(8)) u_ddc_device_fault (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .link(link2),
        .i_low_supply(1'b0), .o_dac_a(), .o_dac_b(), .o_input_a(in2_a), .o_input_b(in2_b), .o_mode_a(),
        .o_mode_b(), .o_ref_buffered(), .o_pending(), .o_amp_connected(), .o_pull_1k(), .o_pull_100k(),
        .o_shutdown(), .o_settled(), .o_frame_done(done2), .o_frame_abort(abort2));
    ddc_link_monitor u_ddc_link_monitor (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_sclk(link.sclk),
        .i_din(link.din), .i_sync_n(link.sync_n), .i_load_strobe_n(link.load_strobe_n));

    ////////////////////////////////////////////////////////////////////////////////
    // Bits as they cross the wire, taken where the receiving end takes them.
    always @(posedge i_sys_clk) begin
        wire_q <= link.sclk;
        if (wire_q && !link.sclk && !link.sync_n) begin
            wire_word <= {wire_word[14:0], link.din};
        end
        if (abort2 === 1'b1) begin
            aborts++;
        end
        if (done2 === 1'b1) begin
            frames2++;
        end
        cycles++;
        if (cycles == 30000) begin
            failures++;
            report_and_stop();
        end
    end

    task automatic check_value(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
        @(posedge i_sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge i_sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge i_sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // One frame through the host; ctrl bit 1 asks for a load strobe after it.
    task automatic send(input logic [15:0] word, input logic [31:0] ctrl);
        apb(1'b1, `DDC_REG_CTRL, ctrl);
        apb(1'b1, `DDC_REG_FRAME, {16'h0000, word});
        while (done !== 1'b1) begin
            @(posedge i_sys_clk);
        end
        if (ctrl[1]) begin
            while (link.load_strobe_n !== 1'b0) begin
                @(posedge i_sys_clk);
            end
            while (link.load_strobe_n !== 1'b1) begin
                @(posedge i_sys_clk);
            end
        end
        repeat (5) @(posedge i_sys_clk);
        check_value({16'h0000, wire_word}, {16'h0000, word});
    endtask

    // Bench-driven frame of nbits clocks on the second link; fewer than 16 is an abort.
    task automatic bb(input logic [15:0] word, input int nbits);
        @(posedge i_sys_clk);
        link2.sync_n <= 1'b0;
        repeat (4) @(posedge i_sys_clk);
        for (int i = 0; i < nbits; i++) begin
            link2.sclk <= 1'b1;
            link2.din <= word[15 - (i % 16)];
            repeat (4) @(posedge i_sys_clk);
            link2.sclk <= 1'b0;
            repeat (4) @(posedge i_sys_clk);
        end
        link2.sync_n <= 1'b1;
        link2.din <= ~link2.din;
        repeat (8) @(posedge i_sys_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        link2.sclk = 1'b0;
        link2.din = 1'b0;
        link2.sync_n = 1'b1;
        link2.load_strobe_n = 1'b1;
        repeat (16) @(posedge i_sys_clk);
        i_nrst <= 1'b1;
        repeat (4) @(posedge i_sys_clk);
        check_value({8'h00, dac_a, dac_b}, 32'h0000_0000);
        check_value({8'h00, in_a, in_b}, 32'h0000_0000);
        check_value({20'h0_0000, mode_a, mode_b, ref_buf, pend, amp, settled}, 32'h0000_000F);
        $display("Test reset state done");
        apb(1'b0, `DDC_REG_CTRL, 32'h0000_0000);
        check_value(rd, `DDC_CTRL_RESET);
        apb(1'b0, 12'h010, 32'h0000_0000);
        check_value({rd[30:0], err}, 32'h0000_0001);
        $display("Test register access done");
        send(16'h4123, 32'h0000_0000);
        check_value({8'h00, in_a, dac_a}, 32'h0012_3000);
        check_value({28'h000_0000, ref_buf, pend}, 32'h0000_0005);
        apb(1'b0, `DDC_REG_LAST, 32'h0000_0000);
        check_value({16'h0000, rd[15:0]}, 32'h0000_4123);
        $display("Test write without load done");
        send(16'h8456, 32'h0000_0003);
        check_value({8'h00, dac_a, dac_b}, 32'h0012_3456);
        check_value({30'h0000_0000, pend}, 32'h0000_0000);
        send(16'h0789, 32'h0000_0002);
        check_value({8'h00, dac_a, dac_b}, 32'h0078_9456);
        $display("Test simultaneous load done");
        for (m = 1; m < 4; m++) begin
            send({2'b10, 2'(m), 12'h456}, 32'h0000_0000);
            check_value({28'h000_0000, mode_a, mode_b}, 32'(m));
            check_value({24'h00_0000, amp, sd, p1k, p100k},
                {24'h00_0000, m == 0, 1'b1, m != 0, 1'b0, m == 1, 1'b0, m == 2, 1'b0});
            check_value({8'h00, dac_b, in_b}, 32'h0045_6456);
        end
        $display("Test power-down modes done");
        for (s = 0; s < 2; s++) begin
            low_supply <= 1'(s);
            send(16'h9456, 32'h0000_0000);
            check_value({31'h0000_0000, settled[1]}, 32'h0000_0000);
            send(16'h8456, 32'h0000_0000);
            repeat (s == 1 ? 40 : 15) @(posedge i_sys_clk);
            check_value({30'h0000_0000, settled}, 32'h0000_0001);
            repeat (40) @(posedge i_sys_clk);
            check_value({30'h0000_0000, settled}, 32'h0000_0003);
        end
        $display("Test recovery delay done");
        bb(16'h0ABC, 16);
        check_value({8'h00, in2_a, in2_b}, 32'h00AB_0000);
        bb(16'h8FFF, 10);
        check_value({8'h00, in2_a, in2_b}, 32'h00AB_0000);
        bb(16'h8123, 20);
        check_value({8'h00, in2_a, in2_b}, 32'h00AB_0120);
        check_value(32'(aborts), 32'h0000_0001);
        check_value(32'(frames2), 32'h0000_0002);
        $display("Test faulty host frames done");
        report_and_stop();
    end
endmodule
